//--- uwf_params.svh
`ifndef UWF_PARAMS_SVH
`define UWF_PARAMS_SVH

// ============================================================
// Timing
`define UWF_CLK_HZ 20000000
`define UWF_MAX_BAUD 1000000
`define UWF_RESET_BAUD 115200
`define UWF_MIN_DIV 16'(`UWF_CLK_HZ / `UWF_MAX_BAUD)
`define UWF_DIV_RESET 16'(`UWF_CLK_HZ / `UWF_RESET_BAUD)

// ============================================================
// Register offsets
`define UWF_OFS_CTRL 8'h00
`define UWF_OFS_STATUS 8'h04
`define UWF_OFS_DIV 8'h08
`define UWF_OFS_TXDATA 8'h0C
`define UWF_OFS_RXDATA 8'h10

// ============================================================
// Control fields and reset value
`define UWF_CTRL_EN 0
`define UWF_CTRL_PAR_EN 1
`define UWF_CTRL_PAR_ODD 2
`define UWF_CTRL_FLOW_EN 3
`define UWF_CTRL_RESET 4'h8

// ============================================================
// Status fields
`define UWF_ST_TX_READY 0
`define UWF_ST_RX_VALID 1
`define UWF_ST_TX_BUSY 2
`define UWF_ST_CTS_ON 3
`define UWF_ST_OVERRUN 4
`define UWF_ST_RTS_ON 5

// ============================================================
// Receive word fields
`define UWF_RX_PERR 8
`define UWF_RX_FERR 9
`define UWF_RX_VALID 10

`endif

//--- uwf_pkg.sv
package uwf_pkg;

    typedef enum logic [2:0]
    {
        UWF_IDLE = 3'b000,
        UWF_START = 3'b001,
        UWF_DATA = 3'b010,
        UWF_PARITY = 3'b011,
        UWF_STOP = 3'b100
    } uwf_state_t;

endpackage

//--- uwf_buf2.sv
`timescale 1ns/100ps

module uwf_buf2
#(
    parameter int W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic [W-1:0] mem [2];
    logic wptr;
    logic rptr;
    logic [1:0] cnt;
    logic push;
    logic pop;

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else if (push)
        begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wptr <= 1'b0;
            rptr <= 1'b0;
            cnt <= 2'h0;
        end
        else
        begin
            wptr <= wptr ^ push;
            rptr <= rptr ^ pop;
            cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
        end
    end

    buf_bound_a: assert property (@(posedge clk_sys) // R1
        disable iff (!rst_b) (cnt == 2'h2 && !pop)
        |=> (cnt == 2'h2 && out_data == $past(out_data)))
        else $error("Full buffer lost a word.");

endmodule

//--- uwf_rx.sv
`timescale 1ns/100ps
`include "uwf_params.svh"

module uwf_rx
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Synchronised line and settings
    input wire logic line,
    input wire logic enable,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic [15:0] div,
    // Received word: ferr, perr, data
    output logic out_valid,
    output logic [9:0] out_data
);

    uwf_pkg::uwf_state_t state;
    logic [15:0] cnt;
    logic [2:0] idx;
    logic [7:0] shreg;
    logic perr;
    logic tick;
    logic half;

    assign tick = (cnt == 16'(div - 16'h0001));
    assign half = (cnt == (div >> 1));

    // Start bit checked at mid-bit; data LSB first, then parity, stop.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= uwf_pkg::UWF_IDLE;
            cnt <= 16'h0000;
            idx <= 3'h0;
            shreg <= 8'h00;
            perr <= 1'b0;
        end
        else
        begin
            cnt <= tick ? 16'h0000 : 16'(cnt + 16'h0001);
            case (state)
                uwf_pkg::UWF_IDLE:
                begin
                    cnt <= 16'h0000;
                    if (enable && !line)
                        state <= uwf_pkg::UWF_START; // R12
                end
                uwf_pkg::UWF_START:
                begin
                    if (half)
                    begin
                        cnt <= 16'h0000;
                        idx <= 3'h0;
                        perr <= 1'b0;
                        state <= line ? uwf_pkg::UWF_IDLE // R11
                                      : uwf_pkg::UWF_DATA;
                    end
                end
                uwf_pkg::UWF_DATA:
                begin
                    if (tick)
                    begin
                        shreg <= {line, shreg[7:1]}; // R12
                        idx <= 3'(idx + 3'h1);
                        if (idx == 3'h7)
                            state <= parity_en ? uwf_pkg::UWF_PARITY
                                               : uwf_pkg::UWF_STOP;
                    end
                end
                uwf_pkg::UWF_PARITY:
                begin
                    if (tick)
                    begin
                        perr <= line ^ (^shreg) ^ parity_odd; // R2
                        state <= uwf_pkg::UWF_STOP;
                    end
                end
                default:
                begin
                    if (tick)
                        state <= uwf_pkg::UWF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid <= 1'b0;
            out_data <= 10'h000;
        end
        else
        begin
            out_valid <= (state == uwf_pkg::UWF_STOP) && tick;
            if ((state == uwf_pkg::UWF_STOP) && tick)
                out_data <= {!line, perr, shreg}; // R12
        end
    end

    rx_glitch_a: assert property (@(posedge clk_sys) // R11
        disable iff (!rst_b) (state == uwf_pkg::UWF_START && half && line)
        |=> (state == uwf_pkg::UWF_IDLE && !out_valid))
        else $error("Short start pulse was not rejected.");

    rx_word_a: assert property (@(posedge clk_sys) // R12
        disable iff (!rst_b) (state == uwf_pkg::UWF_STOP && tick)
        |=> (out_valid && out_data[9] == !$past(line)))
        else $error("Stop bit sample not reported.");

    rx_word_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        out_valid && parity_en);

endmodule

//--- uwf_top.sv
// Overview of operation
// [R1] Full-duplex serial port with handshake, up to one megabit per second.
// [R2] Optional ninth parity bit generated on send and checked on receive.
// [R3] Request-to-send is driven out, clear-to-send sampled; both active low.
// [R4] Transmit and receive lines rest high between characters.
// [R5] Once enabled, transmit output is driven high at idle.
// [R6] Once enabled, request-to-send is driven low when ready for data.
// [R7] Receive input gets an internal pull-up once enabled.
// [R8] Clear-to-send input gets an internal pull-down once enabled.
// [R9] Host transmit feeds our receive line; our transmit feeds host.
// [R10] Host stops sending when request-to-send is deasserted.
// [R11] Framing and handshake follow common industry UART conventions.
// [R12] Low start, data LSB first, optional parity, high stop bit.
`timescale 1ns/100ps
`include "uwf_params.svh"

module uwf_top
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial pins
    output logic gp_pin_serial_out,
    output logic gp_pin_serial_out_oe,
    input wire logic gp_pin_serial_in,
    output logic gp_pin_rts_b,
    output logic gp_pin_rts_oe,
    input wire logic gp_pin_cts_b,
    // Pad bias controls
    output logic serial_in_pull_up_en,
    output logic cts_pull_down_en
);

    // ============================================================
    // Registers and synchronisers
    logic [3:0] ctrl;
    logic [15:0] div;
    logic overrun;
    logic in_meta;
    logic in_sync;
    logic cts_meta;
    logic cts_sync_b;
    logic en;
    logic cts_ok;

    assign en = ctrl[`UWF_CTRL_EN];
    assign cts_ok = !ctrl[`UWF_CTRL_FLOW_EN] || !cts_sync_b; // R3

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_meta <= 1'b1;
            in_sync <= 1'b1;
            cts_meta <= 1'b0;
            cts_sync_b <= 1'b0;
        end
        else
        begin
            in_meta <= gp_pin_serial_in;
            in_sync <= in_meta;
            cts_meta <= gp_pin_cts_b;
            cts_sync_b <= cts_meta;
        end
    end

    // ============================================================
    // Buffers and receiver
    logic txb_in_ready;
    logic txb_valid;
    logic txb_pop;
    logic [7:0] txb_data;
    logic rx_push;
    logic [9:0] rx_word;
    logic rxb_in_ready;
    logic rxb_valid;
    logic rxb_pop;
    logic [9:0] rxb_data;
    logic wr_tx;
    logic rd_rx;

    assign wr_tx = reg_wr && (reg_addr == `UWF_OFS_TXDATA);
    assign rd_rx = reg_rd && (reg_addr == `UWF_OFS_RXDATA);
    assign rxb_pop = rd_rx;

    uwf_buf2 #(.W(8)) u_txb
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(wr_tx),
        .in_ready(txb_in_ready),
        .in_data(reg_wdata[7:0]),
        .out_valid(txb_valid),
        .out_ready(txb_pop),
        .out_data(txb_data)
    );

    uwf_rx u_rx
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .line(in_sync),
        .enable(en),
        .parity_en(ctrl[`UWF_CTRL_PAR_EN]),
        .parity_odd(ctrl[`UWF_CTRL_PAR_ODD]),
        .div(div),
        .out_valid(rx_push),
        .out_data(rx_word)
    );

    uwf_buf2 #(.W(10)) u_rxb
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(rx_push),
        .in_ready(rxb_in_ready),
        .in_data(rx_word),
        .out_valid(rxb_valid),
        .out_ready(rxb_pop),
        .out_data(rxb_data)
    );

    // ============================================================
    // Register writes
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl <= `UWF_CTRL_RESET;
            div <= `UWF_DIV_RESET;
        end
        else if (reg_wr && reg_addr == `UWF_OFS_CTRL)
        begin
            ctrl <= reg_wdata[3:0];
        end
        else if (reg_wr && reg_addr == `UWF_OFS_DIV)
        begin
            // The divisor never drops below one megabit per second.
            div <= (reg_wdata[15:0] < `UWF_MIN_DIV) ? `UWF_MIN_DIV
                                                    : reg_wdata[15:0]; // R1
        end
    end

    // A new overrun in the clearing cycle keeps the flag set.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            overrun <= 1'b0;
        else if (rx_push && !rxb_in_ready)
            overrun <= 1'b1;
        else if (reg_wr && reg_addr == `UWF_OFS_STATUS
                 && reg_wdata[`UWF_ST_OVERRUN])
            overrun <= 1'b0;
    end

    // ============================================================
    // Transmitter
    uwf_pkg::uwf_state_t tx_state;
    uwf_pkg::uwf_state_t next_tx_state;
    logic [15:0] tx_cnt;
    logic [2:0] tx_idx;
    logic [7:0] tx_shreg;
    logic [7:0] next_tx_shreg;
    logic tx_par;
    logic tx_tick;

    assign tx_tick = (tx_cnt == 16'(div - 16'h0001));
    assign txb_pop = (tx_state == uwf_pkg::UWF_IDLE) && en && txb_valid
                     && cts_ok; // R3

    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_shreg = tx_shreg;
        case (tx_state)
            uwf_pkg::UWF_IDLE:
            begin
                if (txb_pop)
                begin
                    next_tx_state = uwf_pkg::UWF_START;
                    next_tx_shreg = txb_data;
                end
            end
            uwf_pkg::UWF_START:
            begin
                if (tx_tick)
                    next_tx_state = uwf_pkg::UWF_DATA;
            end
            uwf_pkg::UWF_DATA:
            begin
                if (tx_tick)
                begin
                    next_tx_shreg = {1'b0, tx_shreg[7:1]};
                    if (tx_idx == 3'h7)
                        next_tx_state = ctrl[`UWF_CTRL_PAR_EN]
                            ? uwf_pkg::UWF_PARITY : uwf_pkg::UWF_STOP;
                end
            end
            uwf_pkg::UWF_PARITY:
            begin
                if (tx_tick)
                    next_tx_state = uwf_pkg::UWF_STOP;
            end
            default:
            begin
                if (tx_tick)
                    next_tx_state = uwf_pkg::UWF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_state <= uwf_pkg::UWF_IDLE;
            tx_cnt <= 16'h0000;
            tx_idx <= 3'h0;
            tx_shreg <= 8'h00;
            tx_par <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_shreg <= next_tx_shreg;
            if (tx_state == uwf_pkg::UWF_IDLE || tx_tick)
                tx_cnt <= 16'h0000;
            else
                tx_cnt <= 16'(tx_cnt + 16'h0001);
            if (tx_state == uwf_pkg::UWF_START)
                tx_idx <= 3'h0;
            else if (tx_state == uwf_pkg::UWF_DATA && tx_tick)
                tx_idx <= 3'(tx_idx + 3'h1);
            if (txb_pop)
                tx_par <= (^txb_data) ^ ctrl[`UWF_CTRL_PAR_ODD]; // R2
        end
    end

    // ============================================================
    // Pins and read data
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gp_pin_serial_out <= 1'b1;
            gp_pin_serial_out_oe <= 1'b0;
            gp_pin_rts_b <= 1'b1;
            gp_pin_rts_oe <= 1'b0;
            serial_in_pull_up_en <= 1'b0;
            cts_pull_down_en <= 1'b0;
        end
        else
        begin
            gp_pin_serial_out_oe <= en; // R5
            gp_pin_rts_oe <= en; // R3
            serial_in_pull_up_en <= en; // R7
            cts_pull_down_en <= en; // R8
            // Ready only while the receive buffer is empty, so one more
            // character still in flight from the host has a free slot.
            gp_pin_rts_b <= !(en && !rxb_valid && !rx_push); // R6 R10
            case (next_tx_state)
                uwf_pkg::UWF_START: gp_pin_serial_out <= 1'b0; // R12
                uwf_pkg::UWF_DATA: gp_pin_serial_out <= next_tx_shreg[0];
                uwf_pkg::UWF_PARITY: gp_pin_serial_out <= tx_par; // R2
                default: gp_pin_serial_out <= 1'b1; // R4 R5
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h00000000;
        else if (!reg_rd)
            reg_rdata <= 32'h00000000;
        else if (reg_addr == `UWF_OFS_CTRL)
            reg_rdata <= {28'h0000000, ctrl};
        else if (reg_addr == `UWF_OFS_DIV)
            reg_rdata <= {16'h0000, div};
        else if (reg_addr == `UWF_OFS_RXDATA)
            reg_rdata <= {21'h000000, rxb_valid, rxb_valid ? rxb_data
                                                           : 10'h000};
        else if (reg_addr == `UWF_OFS_STATUS)
            reg_rdata <= {26'h0000000, !gp_pin_rts_b, overrun, !cts_sync_b,
                          tx_state != uwf_pkg::UWF_IDLE, rxb_valid,
                          txb_in_ready};
        else
            reg_rdata <= 32'h00000000;
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic [15:0] chk_cnt;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            chk_cnt <= 16'h0000;
        else if ($changed(tx_state))
            chk_cnt <= 16'h0001;
        else
            chk_cnt <= 16'(chk_cnt + 16'h0001);
    end

    div_floor_a: assert property (div >= `UWF_MIN_DIV) // R1
        else $error("Bit divisor below the fastest rate.");
    bit_time_a: assert property (($changed(tx_state) // R1
        && $past(tx_state) != uwf_pkg::UWF_IDLE) |-> chk_cnt ==
        (($past(tx_state) == uwf_pkg::UWF_DATA) ? 16'(div << 3) : div))
        else $error("Serial bit held for the wrong time.");
    start_low_a: assert property ($rose(tx_state == uwf_pkg::UWF_START) // R12
        |-> !gp_pin_serial_out ##1 !gp_pin_serial_out)
        else $error("Start bit not low.");
    stop_high_a: assert property ((tx_state == uwf_pkg::UWF_STOP // R4
        || tx_state == uwf_pkg::UWF_IDLE) |-> gp_pin_serial_out)
        else $error("Transmit line low outside a character.");
    parity_bit_a: assert property ($rose(tx_state == uwf_pkg::UWF_PARITY) // R2
        |-> gp_pin_serial_out == tx_par)
        else $error("Parity bit has wrong value.");
    cts_hold_a: assert property ((tx_state == uwf_pkg::UWF_IDLE // R3
        && ctrl[`UWF_CTRL_FLOW_EN] && cts_sync_b)
        |=> tx_state == uwf_pkg::UWF_IDLE)
        else $error("Character started while clear-to-send deasserted.");
    enable_pins_a: assert property ($rose(en) // R5 R7 R8
        |=> gp_pin_serial_out_oe && gp_pin_serial_out
        && serial_in_pull_up_en && cts_pull_down_en)
        else $error("Pins not set up after enable.");
    rts_ready_a: assert property ((en && !rxb_valid && !rx_push) // R6
        ##1 (en && !rxb_valid) |-> !gp_pin_rts_b && gp_pin_rts_oe)
        else $error("Request-to-send not asserted while ready.");
    rts_full_a: assert property (rxb_valid |=> gp_pin_rts_b) // R3
        else $error("Request-to-send asserted with data waiting.");

    tx_par_c: cover property ($rose(tx_state == uwf_pkg::UWF_PARITY));
    cts_stall_c: cover property (txb_valid && en && !cts_ok);
    overrun_c: cover property ($rose(overrun));

endmodule

//--- uwf_host.sv
`timescale 1ns/100ps

module uwf_host
#(
    parameter int DIV = 20
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Device pins as seen on the wires
    input wire logic dev_tx,
    input wire logic dev_rts_b,
    // Host driven lines
    output logic host_tx,
    output logic host_cts_b
);

// ============================================================
// Line drivers
initial
begin
    host_tx = 1'b1;
    host_cts_b = 1'b0;
end

task automatic set_cts(input logic v);
    @(posedge clk_sys);
    host_cts_b <= v;
endtask

// A set flip corrupts the parity bit; ign makes the host ignore the handshake.
task automatic send_char(input logic [7:0] d, input logic pen,
                         input logic podd, input logic flip,
                         input logic ign);
    logic [10:0] bits;
    int n;
    int w;
    w = 0;
    while (!ign && dev_rts_b !== 1'b0 && w < 20000)
    begin
        @(posedge clk_sys);
        w++;
    end
    n = pen ? 11 : 10;
    bits = pen ? {1'b1, ^d ^ podd ^ flip, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < n; i++)
    begin
        @(posedge clk_sys);
        host_tx <= bits[i];
        repeat (DIV - 1) @(posedge clk_sys);
    end
endtask

// Samples each bit of a device character at mid-bit.
task automatic recv_char(input logic pen, input int tmo,
                         output logic [7:0] d, output logic p,
                         output logic ok);
    int w;
    w = 0;
    ok = 1'b0;
    d = 8'h00;
    p = 1'b0;
    while (dev_tx !== 1'b0 && w < tmo)
    begin
        @(posedge clk_sys);
        w++;
    end
    if (w < tmo)
    begin
        repeat (DIV / 2) @(posedge clk_sys);
        ok = (dev_tx === 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            repeat (DIV) @(posedge clk_sys);
            d[i] = dev_tx;
        end
        if (pen)
        begin
            repeat (DIV) @(posedge clk_sys);
            p = dev_tx;
        end
        repeat (DIV) @(posedge clk_sys);
        ok = ok && (dev_tx === 1'b1);
    end
endtask

endmodule

//--- uart_with_hw_flow_control_tb.sv
`timescale 1ns/100ps
`include "uwf_params.svh"

module uart_with_hw_flow_control_tb;

logic clk_sys;
logic rst_b;
logic [7:0] reg_addr;
logic [31:0] reg_wdata;
logic reg_wr;
logic reg_rd;
logic [31:0] reg_rdata;
logic serial_out;
logic serial_out_oe;
logic rts_b;
logic rts_oe;
logic pull_up;
logic pull_dn;
logic host_tx;
logic cts_b;
logic tx_wire;
logic rts_wire;
int fails;
int num_checks;
int cycles;
logic [7:0] rb;
logic [7:0] d;
logic rp;
logic rok;
logic pen;
logic podd;
logic [31:0] rdv;

// Undriven device pins read high on the host side.
assign tx_wire = serial_out_oe ? serial_out : 1'b1;
assign rts_wire = rts_oe ? rts_b : 1'b1;

uwf_top uwf_top_inst
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .gp_pin_serial_out(serial_out),
    .gp_pin_serial_out_oe(serial_out_oe),
    .gp_pin_serial_in(host_tx),
    .gp_pin_rts_b(rts_b),
    .gp_pin_rts_oe(rts_oe),
    .gp_pin_cts_b(cts_b),
    .serial_in_pull_up_en(pull_up),
    .cts_pull_down_en(pull_dn)
);

uwf_host #(.DIV(20)) uwf_host_inst
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .dev_tx(tx_wire),
    .dev_rts_b(rts_wire),
    .host_tx(host_tx),
    .host_cts_b(cts_b)
);

// ============================================================
// Clock and timeout
initial
begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
end

always @(posedge clk_sys)
begin
    cycles++;
    if (cycles == 20000)
    begin
        fails++;
        end_of_test();
    end
end

// ============================================================
// Access tasks
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
endtask

task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
endtask

task automatic chk(input string name, input logic [31:0] e,
                   input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
        fails++;
        $display("Error %s expected %h seen %h", name, e, g);
    end
endtask

task automatic rx_chk(input logic [31:0] e);
    rd(`UWF_OFS_RXDATA, rdv);
    chk("rxdata", e, rdv);
endtask

task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask

// ============================================================
// Tests
initial
begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk("tx_idle", 1, serial_out);
    chk("pins_off", 0, {serial_out_oe, rts_oe, pull_up, pull_dn});
    rd(`UWF_OFS_CTRL, rdv);
    chk("ctrl", 32'h8, rdv);
    rd(`UWF_OFS_DIV, rdv);
    chk("div", 32'hAD, rdv);
    rd(8'h20, rdv);
    chk("unmapped", 32'h0, rdv);
    $display("Test reset done");

    wr(`UWF_OFS_CTRL, 32'h9);
    wr(`UWF_OFS_DIV, 32'h5);
    rd(`UWF_OFS_DIV, rdv);
    chk("div_floor", 32'h14, rdv);
    chk("tx_pin", 2'b11, {serial_out_oe, tx_wire});
    chk("rts_pin", 2'b10, {rts_oe, rts_b});
    chk("pull_up", 1, pull_up);
    chk("pull_dn", 1, pull_dn);
    $display("Test enable done");

    for (int m = 0; m < 3; m++)
    begin
        pen = (m != 0);
        podd = (m == 2);
        d = 8'hA5 + 8'(m);
        wr(`UWF_OFS_CTRL, {28'h0, 1'b1, podd, pen, 1'b1});
        fork
            wr(`UWF_OFS_TXDATA, {24'h0, d});
            uwf_host_inst.recv_char(pen, 400, rb, rp, rok);
            uwf_host_inst.send_char(8'h3C + 8'(m), pen, podd, 1'b0, 1'b0);
        join
        chk("tx_frame", 1, rok);
        chk("tx_byte", d, rb);
        if (pen)
            chk("tx_parity", ^d ^ podd, rp);
        repeat (30) @(posedge clk_sys);
        rx_chk(32'h43C + m);
    end
    $display("Test duplex done");

    wr(`UWF_OFS_CTRL, 32'hB);
    uwf_host_inst.send_char(8'h96, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (30) @(posedge clk_sys);
    rx_chk(32'h596);
    $display("Test parity error done");

    wr(`UWF_OFS_CTRL, 32'h9);
    uwf_host_inst.send_char(8'h5A, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (30) @(posedge clk_sys);
    chk("rts_full", 1, rts_wire);
    rx_chk(32'h45A);
    repeat (5) @(posedge clk_sys);
    chk("rts_empty", 0, rts_wire);
    for (int i = 1; i < 4; i++)
        uwf_host_inst.send_char(8'(i), 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge clk_sys);
    rd(`UWF_OFS_STATUS, rdv);
    chk("overrun", 32'h1B, {26'h0, rdv[5:0]});
    rx_chk(32'h401);
    rx_chk(32'h402);
    rx_chk(32'h0);
    wr(`UWF_OFS_STATUS, 32'h10);
    rd(`UWF_OFS_STATUS, rdv);
    chk("overrun_clr", 0, rdv[4]);
    $display("Test flow done");

    uwf_host_inst.set_cts(1'b1);
    repeat (5) @(posedge clk_sys);
    for (int i = 1; i < 4; i++)
        wr(`UWF_OFS_TXDATA, 32'h80 + i);
    rd(`UWF_OFS_STATUS, rdv);
    chk("tx_ready", 32'h20, {26'h0, rdv[5:0]});
    repeat (60) @(posedge clk_sys);
    chk("cts_stall", 1, tx_wire);
    fork
        uwf_host_inst.set_cts(1'b0);
        uwf_host_inst.recv_char(1'b0, 400, rb, rp, rok);
    join
    chk("tx_first", 9'h181, {rok, rb});
    uwf_host_inst.recv_char(1'b0, 400, rb, rp, rok);
    chk("tx_second", 9'h182, {rok, rb});
    uwf_host_inst.recv_char(1'b0, 400, rb, rp, rok);
    chk("tx_dropped", 0, rok);
    chk("tx_rest", 1, tx_wire);
    wr(`UWF_OFS_CTRL, 32'h1);
    uwf_host_inst.set_cts(1'b1);
    repeat (5) @(posedge clk_sys);
    fork
        wr(`UWF_OFS_TXDATA, 32'h84);
        uwf_host_inst.recv_char(1'b0, 400, rb, rp, rok);
    join
    chk("tx_no_flow", 9'h184, {rok, rb});
    $display("Test clear to send done");
    end_of_test();
end

endmodule
